// ### hdl/processor_data_path.sv
`timescale 1ns/100ps
module processor_data_path (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire dp_pkg::micro_ctl_t   micro_ctl,
    input  wire logic [15:0]          read_bus,
    input  wire logic [15:0]          bus_data_in,
    input  wire logic                 status_carry,
    input  wire logic [15:0]          console_switches,
    input  wire logic [7:0]           buffered_micro_pointer,
    output logic      [15:0]          main_data_r,
    output logic      [15:0]          console_display_r,
    output logic      [15:0]          result_r,
    output logic                      result_carry_r,
    output logic      [15:0]          bus_data_out_r,
    output logic                      bus_data_oe_r,
    output logic      [15:0]          bus_addr_r,
    output dp_pkg::cond_flags_t       flags_r,
    output dp_pkg::addr_decode_t      addr_decode_r,
    output logic                      switch_match_r
);
    import dp_pkg::*;

    logic        rst_meta_b_r;
    logic        rst_sync_b_r;
    logic [15:0] b_reg_r;
    logic [15:0] main_data_select;
    logic [15:0] b_operand_select;
    logic [15:0] bus_address_select;
    logic [15:0] alu_out;
    logic [3:0]  grp_prop;
    logic [3:0]  grp_gen;
    logic [4:0]  grp_carry;
    logic [15:0] result_nxt;
    logic        result_carry_nxt;
    logic [15:0] bus_addr_nxt;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_b_r <= 1'b1;
            rst_sync_b_r <= rst_meta_b_r;
        end
    end

    // Main data select
    always_comb begin
        unique case (micro_ctl.main_data_select)
            MD_RESULT:   main_data_select = result_r;
            MD_BUS_DATA: main_data_select = bus_data_in;
            MD_SHIFT_R:  main_data_select = {result_carry_r, result_r[15:1]};
            MD_READ_BUS: main_data_select = read_bus;
        endcase
    end

    // B operand select
    always_comb begin
        unique case (micro_ctl.b_operand_select)
            BS_B_REG: b_operand_select = b_reg_r;
            BS_SWAP:  b_operand_select = {b_reg_r[7:0], b_reg_r[15:8]};
            BS_ONE:   b_operand_select = CONST_ONE;
            BS_TWO:   b_operand_select = CONST_TWO;
        endcase
    end

    // Four identical slices
    genvar gi;
    generate
        for (gi = 0; gi < GROUPS; gi++) begin : g_slice
            alu_slice u_slice (
                .a        (read_bus[gi*GROUP_W +: GROUP_W]),
                .b        (b_operand_select[gi*GROUP_W +: GROUP_W]),
                .op       (micro_ctl.alu_op),
                .cin      (grp_carry[gi]),
                .f        (alu_out[gi*GROUP_W +: GROUP_W]),
                .grp_prop (grp_prop[gi]),
                .grp_gen  (grp_gen[gi])
            );
        end
    endgenerate

    // Group carry lookahead, each carry in two gate levels
    always_comb begin
        grp_carry[0] = micro_ctl.alu_carry_in;
        grp_carry[1] = grp_gen[0] | (grp_prop[0] & grp_carry[0]);
        grp_carry[2] = grp_gen[1] | (grp_prop[1] & grp_gen[0])
                     | (&grp_prop[1:0] & grp_carry[0]);
        grp_carry[3] = grp_gen[2] | (grp_prop[2] & grp_gen[1])
                     | (&grp_prop[2:1] & grp_gen[0])
                     | (&grp_prop[2:0] & grp_carry[0]);
        grp_carry[4] = grp_gen[3] | (grp_prop[3] & grp_gen[2])
                     | (&grp_prop[3:2] & grp_gen[1])
                     | (&grp_prop[3:1] & grp_gen[0])
                     | (&grp_prop[3:0] & grp_carry[0]);
    end

    // Carry source
    always_comb begin
        unique case (micro_ctl.carry_select)
            CS_WORD:    result_carry_nxt = grp_carry[4];
            CS_BYTE:    result_carry_nxt = grp_carry[2];
            CS_STATUS:  result_carry_nxt = status_carry;
            CS_RESULT0: result_carry_nxt = result_r[0];
        endcase
    end

    always_comb begin
        result_nxt   = micro_ctl.load_result ? alu_out : result_r;
        bus_address_select = (micro_ctl.bus_address_select == BA_READ_BUS) ?
                             read_bus : alu_out;
        bus_addr_nxt = micro_ctl.load_bus_addr ? bus_address_select : bus_addr_r;
    end

    // Data path registers carry no reset
    always_ff @(posedge clk) begin
        if (micro_ctl.load_b) begin
            b_reg_r <= main_data_select;
        end
    end

    // Result register holds data between scratch pad read and rewrite
    always_ff @(posedge clk) begin
        result_r <= result_nxt;
        if (micro_ctl.load_carry) begin
            result_carry_r <= result_carry_nxt;
        end
    end

    always_ff @(posedge clk) begin
        bus_addr_r <= bus_addr_nxt;
    end

    // Write data and console display copies
    always_ff @(posedge clk) begin
        main_data_r       <= main_data_select;
        console_display_r <= main_data_select;
    end

    // Bus data drivers
    always_ff @(posedge clk) begin
        bus_data_out_r <= result_nxt;
    end

    always_ff @(posedge clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            bus_data_oe_r <= OE_RESET;
        end else begin
            bus_data_oe_r <= micro_ctl.bus_from_result_gate;
        end
    end

    // Condition flags follow the result register, the operands, ALU bit 7 and the group 0 carry
    always_ff @(posedge clk) begin
        flags_r.word_zero       <= (result_nxt == ZERO_WORD);
        flags_r.byte_zero       <= (result_nxt[7:0] == ZERO_WORD[7:0]);
        flags_r.low_nibble_zero <= (result_nxt[3:0] == ZERO_WORD[3:0]);
        flags_r.byte_sign       <= result_nxt[7];
        flags_r.a_operand_bit7  <= read_bus[7];
        flags_r.b_operand_bit7  <= b_operand_select[7];
        flags_r.alu_out_bit7    <= alu_out[7];
        flags_r.group0_carry_out <= grp_carry[1];
    end

    // Internal address decode from the bus address register
    always_ff @(posedge clk) begin
        addr_decode_r.status_addr   <= (bus_addr_nxt == ADDR_STATUS);
        addr_decode_r.switches_addr <= (bus_addr_nxt == ADDR_SWITCHES);
        addr_decode_r.reg_addr      <= ((bus_addr_nxt & ADDR_REG_MASK)
                                        == ADDR_REG_BASE);
    end

    // Console switch to micro pointer match
    always_ff @(posedge clk) begin
        switch_match_r <= ~|(console_switches[UPTR_W-1:0] ^ buffered_micro_pointer);
    end

endmodule : processor_data_path

// ### hdl/dp_pkg.sv
// Operation
// - The main data select picks the result register, bus data in, result shifted right or read bus.
// - The main data select output is the common write data for the B operand, scratch pad and status.
// - The result register drives the bus data drivers and feeds back into the main data select.
// - Bus data drivers are enabled from the result register only while bus_from_result_gate is set.
// - The result register and other data path registers, except the bus data driver enable, have no reset and start undefined.
// - The result register holds read-modify-write data so a scratch pad word is not read and written at once.
// - In a rotate right the result register LSB becomes the new carry value.
// - The bus address select loads the bus address register from the ALU or from the read bus.
// - Carries out of each 4-bit group come from a lookahead network, not a ripple.
// - Result bit 7 is given to the condition code logic as the byte sign.
// - Bit 7 of the A operand and of the B operand select go to the status logic for byte overflow.
// - Processor-internal addresses are decoded from the internal bus address register only.
// - The result register is decoded for all-zero and for partial-zero portions.
// - Low console switches are XOR compared with the buffered micro pointer and a match is flagged.
// - The main data select output is also shown on the console data display.
// - All data path registers load on the rising clock edge.
package dp_pkg;

    localparam int WORD_W   = 16;
    localparam int GROUP_W  = 4;
    localparam int GROUPS   = WORD_W / GROUP_W;
    localparam int UPTR_W   = 8;

    // Main data select sources
    localparam logic [1:0] MD_RESULT   = 2'h0;
    localparam logic [1:0] MD_BUS_DATA = 2'h1;
    localparam logic [1:0] MD_SHIFT_R  = 2'h2;
    localparam logic [1:0] MD_READ_BUS = 2'h3;

    // B operand select sources
    localparam logic [1:0] BS_B_REG    = 2'h0;
    localparam logic [1:0] BS_SWAP     = 2'h1;
    localparam logic [1:0] BS_ONE      = 2'h2;
    localparam logic [1:0] BS_TWO      = 2'h3;

    // Bus address select sources
    localparam logic       BA_ALU      = 1'b0;
    localparam logic       BA_READ_BUS = 1'b1;

    // Carry register sources
    localparam logic [1:0] CS_WORD     = 2'h0;
    localparam logic [1:0] CS_BYTE     = 2'h1;
    localparam logic [1:0] CS_STATUS   = 2'h2;
    localparam logic [1:0] CS_RESULT0  = 2'h3;

    // ALU functions
    localparam logic [2:0] ALU_ADD     = 3'h0;
    localparam logic [2:0] ALU_SUB     = 3'h1;
    localparam logic [2:0] ALU_AND     = 3'h2;
    localparam logic [2:0] ALU_OR      = 3'h3;
    localparam logic [2:0] ALU_XOR     = 3'h4;
    localparam logic [2:0] ALU_PASS_A  = 3'h5;
    localparam logic [2:0] ALU_PASS_B  = 3'h6;
    localparam logic [2:0] ALU_NOT_B   = 3'h7;

    // Constant B operands
    localparam logic [15:0] CONST_ONE  = 16'h0001;
    localparam logic [15:0] CONST_TWO  = 16'h0002;

    // Processor-internal addresses
    localparam logic [15:0] ADDR_STATUS   = 16'hFFFE;
    localparam logic [15:0] ADDR_SWITCHES = 16'hFF78;
    localparam logic [15:0] ADDR_REG_BASE = 16'hFF00;
    localparam logic [15:0] ADDR_REG_MASK = 16'hFFF0;

    localparam logic [15:0] ZERO_WORD  = 16'h0000;
    localparam logic        OE_RESET   = 1'b0;

    typedef struct packed {
        logic [1:0] main_data_select;
        logic [1:0] b_operand_select;
        logic [2:0] alu_op;
        logic       alu_carry_in;
        logic       load_b;
        logic       load_result;
        logic       load_carry;
        logic [1:0] carry_select;
        logic       bus_address_select;
        logic       load_bus_addr;
        logic       bus_from_result_gate;
    } micro_ctl_t;

    typedef struct packed {
        logic word_zero;
        logic byte_zero;
        logic low_nibble_zero;
        logic byte_sign;
        logic a_operand_bit7;
        logic b_operand_bit7;
        logic alu_out_bit7;
        logic group0_carry_out;
    } cond_flags_t;

    typedef struct packed {
        logic status_addr;
        logic switches_addr;
        logic reg_addr;
    } addr_decode_t;

endpackage : dp_pkg

// ### hdl/alu_slice.sv
`timescale 1ns/100ps
module alu_slice (
    input  wire logic [3:0] a,
    input  wire logic [3:0] b,
    input  wire logic [2:0] op,
    input  wire logic       cin,
    output logic      [3:0] f,
    output logic            grp_prop,
    output logic            grp_gen
);
    import dp_pkg::*;

    logic [3:0] bb;
    logic [3:0] prop;
    logic [3:0] gen;
    logic [3:0] c;
    logic       arith;

    always_comb begin
        arith = (op == ALU_ADD) || (op == ALU_SUB);
        bb    = (op == ALU_SUB) ? ~b : b;
        prop  = a ^ bb;
        gen   = a & bb;
        // Bit carries expanded per position inside the group
        c[0] = cin;
        c[1] = gen[0] | (prop[0] & cin);
        c[2] = gen[1] | (prop[1] & gen[0]) | (&prop[1:0] & cin);
        c[3] = gen[2] | (prop[2] & gen[1]) | (&prop[2:1] & gen[0]) | (&prop[2:0] & cin);
        grp_prop = arith & (&prop);
        grp_gen  = arith & (gen[3] | (prop[3] & gen[2]) | (&prop[3:2] & gen[1])
                 | (&prop[3:1] & gen[0]));
        unique case (op)
            ALU_ADD, ALU_SUB: f = prop ^ c[3:0];
            ALU_AND:          f = a & b;
            ALU_OR:           f = a | b;
            ALU_XOR:          f = a ^ b;
            ALU_PASS_A:       f = a;
            ALU_PASS_B:       f = b;
            ALU_NOT_B:        f = ~b;
        endcase
    end

endmodule : alu_slice

// ### dv/dp_props.sv
`timescale 1ns/100ps
module dp_props (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire dp_pkg::micro_ctl_t   micro_ctl,
    input wire logic [15:0]          read_bus,
    input wire logic [15:0]          bus_data_in,
    input wire logic [15:0]          console_switches,
    input wire logic [7:0]           buffered_micro_pointer,
    input wire logic [15:0]          main_data_r,
    input wire logic [15:0]          console_display_r,
    input wire logic [15:0]          result_r,
    input wire logic                 result_carry_r,
    input wire logic                 bus_data_oe_r,
    input wire logic [15:0]          bus_addr_r,
    input wire dp_pkg::cond_flags_t  flags_r,
    input wire dp_pkg::addr_decode_t addr_decode_r,
    input wire logic                 switch_match_r
);
    import dp_pkg::*;
    logic [1:0]  rcnt_r;
    logic [15:0] md_exp;
    logic [1:0]  msel;
    assign msel = micro_ctl.main_data_select;
    assign md_exp = msel == MD_RESULT ? result_r : msel == MD_BUS_DATA ? bus_data_in :
                    msel == MD_SHIFT_R ? {result_carry_r, result_r[15:1]} : read_bus;
    // Edges since reset release; the bus enable is synchronised
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rcnt_r <= 2'h0;
        end else if (rcnt_r != 2'h3) begin
            rcnt_r <= rcnt_r + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_settled;
        $stable(result_r) ##1 $stable(result_r);
    endsequence
    a_main_select: assert property (1'b1 |=> main_data_r == $past(md_exp) &&
        console_display_r == main_data_r) else $error("main data wrong");
    a_gate_drive: assert property (rcnt_r == 2'h3 |->
        bus_data_oe_r == $past(micro_ctl.bus_from_result_gate)) else $error("bus enable wrong");
    a_rotate_carry: assert property (micro_ctl.load_carry &&
        micro_ctl.carry_select == CS_RESULT0 |=> result_carry_r == $past(result_r[0]))
        else $error("rotate carry wrong");
    a_result_hold: assert property (!micro_ctl.load_result |=> $stable(result_r))
        else $error("result not held");
    a_addr_source: assert property (micro_ctl.load_bus_addr &&
        micro_ctl.bus_address_select == BA_READ_BUS |=> bus_addr_r == $past(read_bus))
        else $error("bus address wrong");
    a_zero_flags: assert property (s_settled |-> flags_r.word_zero == (result_r == 16'h0000) &&
        flags_r.byte_zero == (result_r[7:0] == 8'h00) && flags_r.byte_sign == result_r[7])
        else $error("result flags wrong");
    a_addr_decode: assert property ($stable(bus_addr_r) |->
        addr_decode_r.status_addr == (bus_addr_r == ADDR_STATUS) &&
        addr_decode_r.switches_addr == (bus_addr_r == ADDR_SWITCHES)) else $error("decode wrong");
    a_switch_match: assert property (1'b1 |=> switch_match_r ==
        ($past(console_switches[7:0]) == $past(buffered_micro_pointer))) else $error("match wrong");
endmodule : dp_props

bind processor_data_path dp_props i_props (
    .clk(clk), .rst_b(rst_b), .micro_ctl(micro_ctl), .read_bus(read_bus),
    .bus_data_in(bus_data_in), .console_switches(console_switches),
    .buffered_micro_pointer(buffered_micro_pointer), .main_data_r(main_data_r),
    .console_display_r(console_display_r), .result_r(result_r),
    .result_carry_r(result_carry_r), .bus_data_oe_r(bus_data_oe_r), .bus_addr_r(bus_addr_r),
    .flags_r(flags_r), .addr_decode_r(addr_decode_r), .switch_match_r(switch_match_r)
);

// ### dv/bus_partner.sv
`timescale 1ns/100ps
module bus_partner (
    input  wire logic        clk,
    input  wire logic        word_valid,
    input  wire logic [15:0] word,
    output logic      [15:0] bus_data_in
);
    logic [15:0] last_r;
    // A released bus shows the inverse of its last value
    assign bus_data_in = word_valid ? word : ~last_r;
    always_ff @(posedge clk) begin
        last_r <= bus_data_in;
    end
endmodule : bus_partner

// ### dv/tb.sv
`timescale 1ns/100ps
module tb;
    import dp_pkg::*;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    micro_ctl_t   mc;
    micro_ctl_t   nop;
    logic [15:0]  rb = 16'h0000;
    logic [15:0]  sw = 16'h0000;
    logic [7:0]   ptr = 8'h00;
    logic [15:0]  wd = 16'h0000;
    logic [15:0]  bus_in, md, disp, res, bout, ba, r_exp;
    logic         rc, oe, match, c_exp;
    cond_flags_t  fl;
    addr_decode_t ad;
    int           failures = 0;
    int           n_tests = 0;
    int           cycles = 0;
    processor_data_path i_dut (.clk(clk), .rst_b(rst_b), .micro_ctl(mc), .read_bus(rb),
        .bus_data_in(bus_in), .status_carry(1'b1), .console_switches(sw),
        .buffered_micro_pointer(ptr), .main_data_r(md), .console_display_r(disp),
        .result_r(res), .result_carry_r(rc), .bus_data_out_r(bout), .bus_data_oe_r(oe),
        .bus_addr_r(ba), .flags_r(fl), .addr_decode_r(ad), .switch_match_r(match));
    bus_partner i_bus (.clk(clk), .word_valid(1'b1), .word(wd), .bus_data_in(bus_in));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1
    task automatic go(input micro_ctl_t w);
        mc = w;
        @(posedge clk);
        #5;
    endtask : go
    task automatic alu(input logic [15:0] a, input logic [2:0] op, input logic [1:0] cs);
        micro_ctl_t w;
        w = nop;
        w.alu_op = op;
        w.load_result = 1'b1;
        w.load_carry = 1'b1;
        w.carry_select = cs;
        rb = a;
        go(w);
    endtask : alu
    task automatic t_arith();
        micro_ctl_t  w;
        logic [16:0] s;
        w = nop;
        w.load_b = 1'b1;
        rb = 16'h00F1;
        go(w);
        for (int op = 0; op < 8; op++) begin
            alu(16'hFF0F, op[2:0], CS_WORD);
            case (op[2:0])
                ALU_ADD: s = 17'h0FF0F + 17'h000F1;
                ALU_SUB: s = 17'h0FF0F + 17'h0FF0E;
                ALU_AND: s = 17'h00001;
                ALU_OR: s = 17'h0FFFF;
                ALU_XOR: s = 17'h0FFFE;
                ALU_PASS_A: s = 17'h0FF0F;
                ALU_PASS_B: s = 17'h000F1;
                default: s = 17'h0FF0E;
            endcase
            if (op < 2) begin
                chk1(rc, s[16]);
                chk1(fl.group0_carry_out, 1'b1);
            end
            chk1(fl.a_operand_bit7, 1'b0);
            chk1(fl.b_operand_bit7, 1'b1);
            chk1(fl.alu_out_bit7, s[7]);
            go(nop);
            go(nop);
            chk16(res, s[15:0]);
            chk1(fl.byte_zero, s[7:0] == 8'h00);
            chk1(fl.low_nibble_zero, s[3:0] == 4'h0);
            chk1(fl.word_zero, s[15:0] == 16'h0000);
            chk1(fl.byte_sign, s[7]);
        end
    endtask : t_arith
    task automatic t_sources();
        micro_ctl_t  w;
        logic [1:0]  sel [4] = '{MD_RESULT, MD_BUS_DATA, MD_SHIFT_R, MD_READ_BUS};
        logic [15:0] e [4] = '{16'hA5C3, 16'h1E2D, 16'hD2E1, 16'h3C5A};
        alu(16'hA5C3, ALU_PASS_A, CS_STATUS);
        rb = 16'h3C5A;
        wd = 16'h1E2D;
        for (int i = 0; i < 4; i++) begin
            w = nop;
            w.main_data_select = sel[i];
            go(w);
            chk16(md, e[i]);
            chk16(disp, e[i]);
        end
        w.main_data_select = MD_BUS_DATA;
        w.load_b = 1'b1;
        go(w);
        alu(16'h0000, ALU_PASS_B, CS_STATUS);
        chk16(res, 16'h1E2D);
        r_exp = 16'h1E2D;
        c_exp = 1'b1;
        for (int i = 0; i < 3; i++) begin
            w = nop;
            w.main_data_select = MD_SHIFT_R;
            w.load_b = 1'b1;
            w.load_carry = 1'b1;
            w.carry_select = CS_RESULT0;
            go(w);
            chk1(rc, r_exp[0]);
            w = nop;
            w.alu_op = ALU_PASS_B;
            w.load_result = 1'b1;
            go(w);
            {c_exp, r_exp} = {r_exp[0], c_exp, r_exp[15:1]};
            chk16(res, r_exp);
        end
        w = nop;
        w.bus_from_result_gate = 1'b1;
        go(w);
        chk1(oe, 1'b1);
        chk16(bout, r_exp);
        go(nop);
        chk1(oe, 1'b0);
    endtask : t_sources
    task automatic t_addr();
        micro_ctl_t  w;
        logic        src [3] = '{BA_READ_BUS, BA_ALU, BA_READ_BUS};
        logic [15:0] a [3] = '{16'hFFFE, 16'hFF76, 16'hFF05};
        logic [15:0] ea [3] = '{16'hFFFE, 16'hFF78, 16'hFF05};
        logic [2:0]  ed [3] = '{3'h4, 3'h2, 3'h1};
        for (int i = 0; i < 3; i++) begin
            w = nop;
            w.bus_address_select = src[i];
            w.load_bus_addr = 1'b1;
            w.b_operand_select = BS_TWO;
            rb = a[i];
            go(w);
            go(nop);
            chk16(ba, ea[i]);
            chk16({13'h0000, ad}, {13'h0000, ed[i]});
        end
        sw = 16'hFF5A;
        ptr = 8'h5A;
        go(nop);
        chk1(match, 1'b1);
        ptr = 8'h5B;
        go(nop);
        chk1(match, 1'b0);
    endtask : t_addr
    initial begin
        micro_ctl_t w;
        nop = '0;
        nop.main_data_select = MD_READ_BUS;
        w = nop;
        w.load_b = 1'b1;
        w.load_result = 1'b1;
        w.load_carry = 1'b1;
        w.load_bus_addr = 1'b1;
        mc = w;
        repeat (20) @(posedge clk);
        #5;
        rst_b = 1'b1;
        go(nop);
        go(nop);
        go(nop);
        chk1(oe, 1'b0);
        t_arith();
        t_sources();
        t_addr();
        stop_test();
    end
endmodule : tb
